// file: design/msm_top.sv
// Function
// - A muting cycle starts when both sensors of the first or the second pair are active.
// - Handover to the second pair only while all four sensors are active.
// - After handover, muting holds while both second pair sensors stay active.
// - Sequential mode ends the bypass once either second pair sensor is free.
// - Confirm input must rise before the first pair completes, else no start.
// - Two-sensor mode holds only while pair active and confirm came first.
// - Four-sensor mode runs both ways unless confirm or setting fixes direction.
// - Two-sensor mode passes material in the configured direction only.
// - Guards: simultaneity time, total time, end by field, sequence check.
// - An error stays until a full valid muting cycle or override.
// - While an error stands, release is low and the error flag high.
`timescale 1ns/1ps
`default_nettype none

module msm_top import msm_pkg::*; #(
  parameter logic [31:0] SIM_CYC_RST = SIM_CYC,
  parameter logic [31:0] TOT_CYC_RST = TOT_CYC
) (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_n,
  // Avalon-MM slave
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  // Sensor and safety device pins
  input  wire logic        first_pair_sensor_one,
  input  wire logic        first_pair_sensor_two,
  input  wire logic        second_pair_sensor_one,
  input  wire logic        second_pair_sensor_two,
  input  wire logic        direction_confirm_input,
  input  wire logic        field_free,
  input  wire logic        override_req,
  // Results
  output logic             release_out,
  output logic             muting_active,
  output logic             muting_error,
  output logic             error_flag,
  output logic             irq
);

  // ****************************************************************
  // Reset release and pin synchronisation
  // ****************************************************************

  logic rst_meta_ff;
  logic rst_sync_ff;

  // Reset asserts at once but leaves through two flops.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end

  msm_sens_s pin_raw;
  msm_sens_s s;

  assign pin_raw = '{first_pair_sensor_one, first_pair_sensor_two,
                     second_pair_sensor_one, second_pair_sensor_two,
                     direction_confirm_input, field_free, override_req};

  msm_sync #(.W($bits(msm_sens_s))) u_sync (
    .mclk  (mclk),
    .rst_n (rst_sync_ff),
    .din   (pin_raw),
    .dout  (s)
  );

  // ****************************************************************
  // Registers
  // ****************************************************************

  logic [7:0]  ctrl_ff;
  logic [3:0]  event_ff;
  logic [3:0]  mask_ff;
  logic [31:0] sim_lim_ff;
  logic [31:0] tot_lim_ff;
  logic        wait_ff;
  logic [31:0] rdata_ff;
  logic        irq_ff;

  msm_state_e  state_ff;
  msm_state_e  nxt_state;
  logic        dir_rev_ff;
  logic        conf_seen_ff;
  logic        lock_ff;
  logic        cut_ff;
  logic        err_ff;
  logic        armed_ff;
  logic        release_ff;
  logic        muting_ff;
  logic        err_flag_ff;

  // Byte-lane merge, shared by every writable register.
  function automatic logic [31:0] be_merge(input logic [31:0] old,
                                           input logic [31:0] wd,
                                           input logic [3:0]  be);
    logic [31:0] r;
    r = old;
    for (int k = 0; k < 4; k++) begin
      if (be[k]) begin
        r[k*8 +: 8] = wd[k*8 +: 8];
      end
    end
    return r;
  endfunction

  // ****************************************************************
  // Bus decode
  // ****************************************************************

  msm_req_s req;
  wire      acc_go;
  wire      wr_go;
  wire      wr_ctrl;
  wire      wr_event;
  wire      wr_mask;
  wire      wr_sim;
  wire      wr_tot;
  wire      mode_two;
  wire      dir_fix;
  wire      cfg_rev;
  wire      use_conf;
  logic [31:0] rd_mux;
  logic [31:0] wmerge;

  assign req      = '{avs_address, avs_read, avs_write, avs_writedata,
                      avs_byteenable};
  // One wait state: accepted while waitrequest is high, answered next edge.
  assign acc_go   = (req.read || req.write) && wait_ff;
  assign wr_go    = req.write && !wait_ff;
  assign wr_ctrl  = wr_go && (req.address == OFS_CTRL);
  assign wr_event = wr_go && (req.address == OFS_EVENT);
  assign wr_mask  = wr_go && (req.address == OFS_MASK);
  assign wr_sim   = wr_go && (req.address == OFS_SIMTIM);
  assign wr_tot   = wr_go && (req.address == OFS_TOTTIM);
  assign wmerge   = be_merge(32'h0000_0000, req.writedata, req.byteenable);

  assign mode_two = ctrl_ff[CB_TWO_SENSOR];
  assign dir_fix  = ctrl_ff[CB_DIR_FIXED];
  assign cfg_rev  = ctrl_ff[CB_DIR_REV];
  assign use_conf = ctrl_ff[CB_USE_CONF];

  // Unmapped addresses read as zero and ignore writes.
  always_comb begin
    case (req.address)
      OFS_CTRL:   rd_mux = {24'h00_0000, ctrl_ff};
      OFS_STATE:  rd_mux = {23'h00_0000, conf_seen_ff, dir_rev_ff,
                            release_ff, err_ff, muting_ff, state_ff};
      OFS_EVENT:  rd_mux = {28'h000_0000, event_ff};
      OFS_MASK:   rd_mux = {28'h000_0000, mask_ff};
      OFS_SIMTIM: rd_mux = sim_lim_ff;
      OFS_TOTTIM: rd_mux = tot_lim_ff;
      default:    rd_mux = 32'h0000_0000;
    endcase
  end

  // ****************************************************************
  // Sensor conditions
  // ****************************************************************

  wire pa;
  wire pb;
  wire all4;
  wire all_free;
  wire allow_fwd;
  wire allow_rev;
  wire start_fwd;
  wire start_rev;
  wire start_req;
  wire conf_ok;
  wire go;
  wire refuse;
  wire p1;
  wire p2;
  wire two_pair;
  wire one_of_start;
  wire muting;
  wire sim_exp;
  wire tot_exp;
  wire tot_err;
  wire sim_err;
  wire seq_err;
  wire safe_end;
  wire end_ok;
  wire end_any;
  wire set_err;
  wire clr_err;
  logic [3:0] ev_in;

  assign pa       = s.first_pair_sensor_one && s.first_pair_sensor_two;
  assign pb       = s.second_pair_sensor_one && s.second_pair_sensor_two;
  assign all4     = pa && pb;
  assign all_free = !(s.first_pair_sensor_one || s.first_pair_sensor_two ||
                      s.second_pair_sensor_one || s.second_pair_sensor_two);

  // A fixed direction comes from the setting or from the confirm input.
  assign allow_fwd = !(dir_fix || use_conf) || !cfg_rev;
  assign allow_rev = !(dir_fix || use_conf) || cfg_rev;
  assign two_pair  = cfg_rev ? pb : pa;
  assign start_fwd = mode_two ? (two_pair && !cfg_rev) : (pa && allow_fwd);
  assign start_rev = mode_two ? (two_pair && cfg_rev) : (pb && allow_rev);
  assign start_req = (start_fwd || start_rev) && !lock_ff;
  assign conf_ok   = !use_conf || conf_seen_ff;
  assign go        = (state_ff == ST_IDLE) && start_req && conf_ok;
  assign refuse    = (state_ff == ST_IDLE) && start_req && !conf_ok;

  // The pair that opened the cycle and the pair that takes over.
  assign p1 = dir_rev_ff ? pb : pa;
  assign p2 = dir_rev_ff ? pa : pb;

  assign muting = (state_ff != ST_IDLE);

  // Simultaneity: only one sensor of either pair while idle.
  assign one_of_start = (state_ff == ST_IDLE) &&
    ((s.first_pair_sensor_one ^ s.first_pair_sensor_two) ||
     (s.second_pair_sensor_one ^ s.second_pair_sensor_two));

  msm_timer u_sim (
    .mclk    (mclk),
    .rst_n   (rst_sync_ff),
    .run     (one_of_start && !lock_ff),
    .limit   (sim_lim_ff),
    .expired (sim_exp)
  );

  msm_timer u_tot (
    .mclk    (mclk),
    .rst_n   (rst_sync_ff),
    .run     (muting),
    .limit   (tot_lim_ff),
    .expired (tot_exp)
  );

  assign sim_err  = sim_exp && ctrl_ff[CB_SIM_EN];
  assign tot_err  = tot_exp && ctrl_ff[CB_TOT_EN];
  // Sequence check: the entry pair broke before the handover happened.
  assign seq_err  = ctrl_ff[CB_SEQ_MON] && (state_ff == ST_FIRST) &&
                    !p1 && !all4;
  // The field cleared again after an interruption during muting.
  assign safe_end = ctrl_ff[CB_SAFE_END] && muting && cut_ff &&
                    s.field_free;

  // ****************************************************************
  // Muting sequence
  // ****************************************************************

  // Any guard failure drops muting at once; only clean exits count as valid.
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: begin
        if (go) begin
          nxt_state = mode_two ? ST_TWO : ST_FIRST;
        end
      end
      ST_FIRST: begin
        if (tot_err || safe_end) begin
          nxt_state = ST_IDLE;
        end else if (all4) begin
          nxt_state = ST_SECOND;
        end else if (!p1) begin
          nxt_state = ST_IDLE;
        end
      end
      ST_SECOND: begin
        if (tot_err || safe_end || !p2) begin
          nxt_state = ST_IDLE;
        end
      end
      ST_TWO: begin
        if (tot_err || safe_end || !(cfg_rev ? pb : pa)) begin
          nxt_state = ST_IDLE;
        end
      end
      default: nxt_state = ST_IDLE;
    endcase
  end

  assign end_any = muting && (nxt_state == ST_IDLE);
  assign end_ok  = end_any && !tot_err &&
                   ((state_ff == ST_SECOND) || (state_ff == ST_TWO) || safe_end);
  assign set_err = sim_err || tot_err || seq_err || refuse;
  // Override, or a free field and sensors followed by a valid pass, clears.
  assign clr_err = s.override_req || (armed_ff && end_ok);

  assign ev_in = {clr_err && err_ff && !set_err, set_err, end_any, go};

  always_ff @(posedge mclk or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      state_ff <= ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Direction is latched at the start of each cycle.
  always_ff @(posedge mclk or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      dir_rev_ff <= 1'b0;
    end else if (go) begin
      dir_rev_ff <= !start_fwd;
    end
  end

  // Confirm counts only while it stands and came before the entry pair was
  // complete; dropping it in idle forgets it, so a stale confirm cannot arm a pass.
  always_ff @(posedge mclk or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      conf_seen_ff <= 1'b0;
    end else if (end_any || ((state_ff == ST_IDLE) && !s.direction_confirm_input)) begin
      conf_seen_ff <= 1'b0;
    end else if ((state_ff == ST_IDLE) && s.direction_confirm_input &&
                 !start_req) begin
      conf_seen_ff <= 1'b1;
    end
  end

  // After any exit, wait until neither pair is complete so no re-entry happens.
  always_ff @(posedge mclk or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      lock_ff <= 1'b0;
    end else if (end_any || refuse) begin
      lock_ff <= 1'b1;
    end else if (!pa && !pb) begin
      lock_ff <= 1'b0;
    end
  end

  // Remembers that the field was broken during this muting cycle.
  always_ff @(posedge mclk or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      cut_ff <= 1'b0;
    end else if (!muting) begin
      cut_ff <= 1'b0;
    end else if (!s.field_free) begin
      cut_ff <= 1'b1;
    end
  end

  // ****************************************************************
  // Error hold and outputs
  // ****************************************************************

  // A new error wins over a clear arriving in the same cycle.
  always_ff @(posedge mclk or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      err_ff   <= 1'b0;
      armed_ff <= 1'b0;
    end else begin
      err_ff   <= set_err || (err_ff && !clr_err);
      armed_ff <= err_ff && !clr_err &&
                  (armed_ff || (all_free && s.field_free));
    end
  end

  // Release never rises while an error is held.
  always_ff @(posedge mclk or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      release_ff  <= 1'b0;
      muting_ff   <= 1'b0;
      err_flag_ff <= 1'b0;
    end else begin
      release_ff  <= !err_ff && (s.field_free || muting);
      muting_ff   <= muting;
      err_flag_ff <= err_ff;
    end
  end

  // ****************************************************************
  // Register file and bus answer
  // ****************************************************************

  always_ff @(posedge mclk or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      ctrl_ff    <= CTRL_RST;
      mask_ff    <= MASK_RST;
      sim_lim_ff <= SIM_CYC_RST;
      tot_lim_ff <= TOT_CYC_RST;
    end else begin
      if (wr_ctrl && req.byteenable[0]) begin
        ctrl_ff <= wmerge[7:0];
      end
      if (wr_mask && req.byteenable[0]) begin
        mask_ff <= wmerge[3:0];
      end
      if (wr_sim) begin
        sim_lim_ff <= be_merge(sim_lim_ff, req.writedata, req.byteenable);
      end
      if (wr_tot) begin
        tot_lim_ff <= be_merge(tot_lim_ff, req.writedata, req.byteenable);
      end
    end
  end

  // Sticky events: write one to clear, a fresh event wins.
  always_ff @(posedge mclk or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      event_ff <= 4'h0;
      irq_ff   <= 1'b0;
    end else begin
      event_ff <= (event_ff & ~(wr_event ? wmerge[3:0] : 4'h0)) | ev_in;
      irq_ff   <= |(((event_ff & ~(wr_event ? wmerge[3:0] : 4'h0)) | ev_in)
                    & mask_ff);
    end
  end

  // Waitrequest idles high and drops for exactly one cycle per access.
  always_ff @(posedge mclk or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      wait_ff  <= 1'b1;
      rdata_ff <= 32'h0000_0000;
    end else begin
      wait_ff <= !acc_go;
      if (acc_go && req.read) begin
        rdata_ff <= rd_mux;
      end
    end
  end

  assign avs_waitrequest = wait_ff;
  assign avs_readdata    = rdata_ff;
  assign release_out     = release_ff;
  assign muting_active   = muting_ff;
  assign muting_error    = err_flag_ff;
  assign error_flag      = err_flag_ff;
  assign irq             = irq_ff;

endmodule

`default_nettype wire

// file: design/msm_pkg.sv
package msm_pkg;

  // ****************************************************************
  // Register map (byte addresses) and field positions
  // ****************************************************************
  localparam logic [4:0] OFS_CTRL   = 5'h00;
  localparam logic [4:0] OFS_STATE  = 5'h04;
  localparam logic [4:0] OFS_EVENT  = 5'h08;
  localparam logic [4:0] OFS_MASK   = 5'h0c;
  localparam logic [4:0] OFS_SIMTIM = 5'h10;
  localparam logic [4:0] OFS_TOTTIM = 5'h14;

  // Control bit positions.
  localparam int CB_TWO_SENSOR = 0;
  localparam int CB_DIR_FIXED  = 1;
  localparam int CB_DIR_REV    = 2;
  localparam int CB_USE_CONF   = 3;
  localparam int CB_SIM_EN     = 4;
  localparam int CB_TOT_EN     = 5;
  localparam int CB_SAFE_END   = 6;
  localparam int CB_SEQ_MON    = 7;

  // Event bit positions.
  localparam int EV_START = 0;
  localparam int EV_END   = 1;
  localparam int EV_ERR   = 2;
  localparam int EV_CLR   = 3;

  localparam logic [7:0] CTRL_RST = 8'hb0;
  localparam logic [3:0] MASK_RST = 4'h0;

  // ****************************************************************
  // Guard times
  // ****************************************************************
  localparam int CLK_MHZ     = 200;
  localparam int SIM_TIME_US = 3000;
  localparam int TOT_TIME_MS = 60;
  localparam logic [31:0] SIM_CYC = 32'(SIM_TIME_US * CLK_MHZ);
  localparam logic [31:0] TOT_CYC = 32'(TOT_TIME_MS * 1000 * CLK_MHZ);

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef struct packed {
    logic first_pair_sensor_one;
    logic first_pair_sensor_two;
    logic second_pair_sensor_one;
    logic second_pair_sensor_two;
    logic direction_confirm_input;
    logic field_free;
    logic override_req;
  } msm_sens_s;

  typedef struct packed {
    logic [4:0]  address;
    logic        read;
    logic        write;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
  } msm_req_s;

  typedef enum logic [3:0] {
    ST_IDLE   = 4'b0001,
    ST_FIRST  = 4'b0010,
    ST_SECOND = 4'b0100,
    ST_TWO    = 4'b1000
  } msm_state_e;

endpackage

// file: design/msm_sync.sv
`timescale 1ns/1ps
`default_nettype none

// Two-stage synchroniser, one pair of flip-flops per bit.
module msm_sync import msm_pkg::*; #(
  parameter int W = 7
) (
  // Clock and reset
  input  wire logic         mclk,
  input  wire logic         rst_n,
  // Data
  input  wire logic [W-1:0] din,
  output var  logic [W-1:0] dout
);

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      logic meta_ff;
      // The first stage feeds only the second stage.
      always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
          meta_ff <= 1'b0;
          dout[i] <= 1'b0;
        end else begin
          meta_ff <= din[i];
          dout[i] <= meta_ff;
        end
      end
    end
  endgenerate

endmodule

`default_nettype wire

// file: design/msm_timer.sv
`timescale 1ns/1ps
`default_nettype none

// Counts while run is high, clears when it drops, flags the limit.
module msm_timer import msm_pkg::*; (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_n,
  // Control
  input  wire logic        run,
  input  wire logic [31:0] limit,
  output logic             expired
);

  logic [31:0] cnt_ff;

  // Saturates at the limit so a long stall cannot wrap back to zero.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff <= 32'h0000_0000;
    end else if (!run) begin
      cnt_ff <= 32'h0000_0000;
    end else if (cnt_ff != limit) begin
      cnt_ff <= cnt_ff + 32'h0000_0001;
    end
  end

  assign expired = run && (cnt_ff == limit);

endmodule

`default_nettype wire

// file: test/msm_top_properties.sv
`timescale 1ns/1ps
`default_nettype none

// ********************
// Port checker
// ********************
module msm_top_checker (
  // Clock and reset
  input wire logic        mclk,
  input wire logic        rst_n,
  // Register bus
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  // Pins
  input wire logic        first_pair_sensor_one,
  input wire logic        first_pair_sensor_two,
  input wire logic        second_pair_sensor_one,
  input wire logic        second_pair_sensor_two,
  input wire logic        field_free,
  // Results
  input wire logic        release_out,
  input wire logic        muting_active,
  input wire logic        muting_error,
  input wire logic        error_flag
);
  logic pa;
  logic pb;

  // Complete pairs at the pins; the sync stages make every relation lag.
  assign pa = first_pair_sensor_one & first_pair_sensor_two;
  assign pb = second_pair_sensor_one & second_pair_sensor_two;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  property p_start;
    $rose(muting_active) |-> $past(pa, 3) || $past(pb, 3);
  endproperty
  a_start: assert property (p_start) else $error("muting without a full pair");
  property p_end;
    (!pa && !pb) [*4] |=> !muting_active;
  endproperty
  a_end: assert property (p_end) else $error("muting held with no full pair");
  property p_err_rel;
    muting_error ##1 muting_error |-> !release_out;
  endproperty
  a_err_rel: assert property (p_err_rel) else $error("release during error");
  property p_flag;
    error_flag == muting_error;
  endproperty
  a_flag: assert property (p_flag) else $error("error flag differs");
  property p_rel_low;
    (!field_free) [*5] ##0 !muting_active |-> !release_out;
  endproperty
  a_rel_low: assert property (p_rel_low) else $error("release without cause");
  // The bus answers with exactly one wait state, and read data move only then.
  property p_wait_pulse;
    !avs_waitrequest |=> avs_waitrequest;
  endproperty
  a_wait_pulse: assert property (p_wait_pulse) else $error("waitrequest low too long");
  property p_wait_ans;
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_wait_ans: assert property (p_wait_ans) else $error("request not answered");
  property p_rdata;
    $changed(avs_readdata) |-> avs_read && !avs_waitrequest;
  endproperty
  a_rdata: assert property (p_rdata) else $error("read data moved outside an answer");
endmodule

bind msm_top msm_top_checker u_msm_top_checker (
  .mclk, .rst_n, .avs_read, .avs_write, .avs_readdata, .avs_waitrequest,
  .first_pair_sensor_one, .first_pair_sensor_two, .second_pair_sensor_one,
  .second_pair_sensor_two, .field_free, .release_out, .muting_active,
  .muting_error, .error_flag
);

`default_nettype wire

// file: test/msm_sens_model.sv
`timescale 1ns/1ps
`default_nettype none

// ********************
// Sensor and curtain model
// ********************
module msm_sens_model import msm_pkg::*; (
  // Clock and reset
  input  wire logic      mclk,
  input  wire logic      rst_n,
  // Commanded levels and pace
  input  wire msm_sens_s want,
  input  wire logic      slow,
  // Pins toward the monitor
  output var  msm_sens_s pins
);
  logic [6:0] diff;
  logic [6:0] low1;
  logic [2:0] gap_ff;

  // Lowest differing bit moves first, so confirm always leads the pair.
  assign diff = want ^ pins;
  assign low1 = diff & (~diff + 7'h01);

  // One pin per step; a slow pace spaces steps like a slow conveyor.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pins   <= '0;
      gap_ff <= 3'h0;
    end else if (gap_ff != 3'h0) begin
      gap_ff <= gap_ff - 3'h1;
    end else if (diff != 7'h00) begin
      pins   <= msm_sens_s'(pins ^ low1);
      gap_ff <= slow ? 3'h7 : 3'h0;
    end
  end
endmodule

`default_nettype wire

// file: test/msm_top_tb.sv
`timescale 1ns/1ps
`default_nettype none

// ********************
// Bench
// ********************
module msm_top_tb import msm_pkg::*; ;
  localparam logic [6:0] PA = 7'h60;
  localparam logic [6:0] PB = 7'h18;
  localparam logic [6:0] PC = 7'h04;
  localparam logic [6:0] PF = 7'h02;
  localparam logic [6:0] PO = 7'h01;
  logic        mclk = 1'b0;
  logic        rst_n = 1'b0;
  logic [4:0]  avs_address = 5'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0]  avs_byteenable = 4'hf;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        release_out;
  logic        muting_active;
  logic        muting_error;
  logic        error_flag;
  logic        irq;
  msm_sens_s   want = '0;
  logic        slow = 1'b0;
  msm_sens_s   p;
  logic [31:0] q;
  int          n_fail = 0;
  int          total_checks = 0;
  int          cyc = 0;

  // Short guard limits keep the run brief.
  msm_top #(.SIM_CYC_RST(32'h14), .TOT_CYC_RST(32'hc8)) u_msm_top (
    .mclk, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest,
    .first_pair_sensor_one(p.first_pair_sensor_one),
    .first_pair_sensor_two(p.first_pair_sensor_two),
    .second_pair_sensor_one(p.second_pair_sensor_one),
    .second_pair_sensor_two(p.second_pair_sensor_two),
    .direction_confirm_input(p.direction_confirm_input),
    .field_free(p.field_free), .override_req(p.override_req),
    .release_out, .muting_active, .muting_error, .error_flag, .irq
  );
  msm_sens_model u_msm_sens_model (.mclk, .rst_n, .want, .slow, .pins(p));

  // Clock of 5 ns.
  always #2.5 mclk = ~mclk;

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Request holds until waitrequest is sampled low at an edge.
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    @(posedge mclk);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= w;
    avs_read      <= !w;
    @(posedge mclk);
    while (avs_waitrequest !== 1'b0) @(posedge mclk);
    q = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic rchk(input logic [4:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk("register", q, e);
  endtask

  // Sets the pins, waits, then checks state bits and the outputs.
  task automatic step(input logic [6:0] v, input int n, input logic [31:0] st,
                      input logic [4:0] ov);
    want <= msm_sens_s'(v);
    repeat (n) @(posedge mclk);
    bus(1'b0, OFS_STATE, 32'h0);
    chk("state", q & 32'h3f, st);
    chk("outputs", {27'h0, release_out, muting_active, muting_error, error_flag, irq},
        {27'h0, ov});
  endtask

  task automatic complete_run();
    $display("checks %0d failures %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // A hang counts as a failure.
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      complete_run();
    end
  end

  initial begin
    repeat (10) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (8) @(posedge mclk);
    rchk(OFS_CTRL, 32'(CTRL_RST));
    rchk(OFS_MASK, 32'(MASK_RST));
    rchk(OFS_SIMTIM, 32'h14);
    rchk(OFS_TOTTIM, 32'hc8);
    bus(1'b1, 5'h18, 32'hffffffff);
    rchk(5'h18, 32'h0);
    bus(1'b1, OFS_STATE, 32'h0);
    rchk(OFS_STATE, 32'h1);
    bus(1'b1, OFS_MASK, 32'hf);
    rchk(OFS_MASK, 32'hf);
    $display("test registers done");
    bus(1'b1, OFS_CTRL, 32'h0);
    step(PA, 24, 32'h12, 5'h19);
    step(PA | PB, 24, 32'h14, 5'h19);
    step(PB, 24, 32'h14, 5'h19);
    step(7'h08, 24, 32'h01, 5'h01);
    rchk(OFS_EVENT, 32'h3);
    bus(1'b1, OFS_EVENT, 32'hf);
    bus(1'b1, OFS_MASK, 32'h0);
    step(PB, 24, 32'h12, 5'h18);
    step(PA | PB, 24, 32'h14, 5'h18);
    step(PA, 24, 32'h14, 5'h18);
    step(7'h20, 24, 32'h01, 5'h00);
    rchk(OFS_EVENT, 32'h3);
    // A fixed forward direction refuses a pass that enters at the second pair.
    bus(1'b1, OFS_CTRL, 32'h2);
    step(PB, 24, 32'h01, 5'h00);
    $display("test four-sensor done");
    bus(1'b1, OFS_CTRL, 32'h8);
    step(PC | PA, 24, 32'h12, 5'h18);
    step(7'h00, 24, 32'h01, 5'h00);
    step(PA, 24, 32'h21, 5'h06);
    step(PA | PC, 24, 32'h21, 5'h06);
    step(PO, 24, 32'h01, 5'h00);
    rchk(OFS_EVENT, 32'hf);
    $display("test confirm done");
    bus(1'b1, OFS_CTRL, 32'h9);
    step(PC | PA, 24, 32'h18, 5'h18);
    step(PC | 7'h40, 24, 32'h01, 5'h00);
    want <= msm_sens_s'(PC | PB);
    repeat (24) @(posedge mclk);
    chk("muting", {31'h0, muting_active}, 32'h0);
    step(PO, 24, 32'h01, 5'h00);
    bus(1'b1, OFS_CTRL, 32'hd);
    step(PC | PB, 24, 32'h18, 5'h18);
    step(7'h00, 24, 32'h01, 5'h00);
    $display("test two-sensor done");
    bus(1'b1, OFS_CTRL, 32'h10);
    step(7'h40, 60, 32'h21, 5'h06);
    step(PO, 24, 32'h01, 5'h00);
    bus(1'b1, OFS_CTRL, 32'h20);
    step(PA, 24, 32'h12, 5'h18);
    step(PA, 240, 32'h21, 5'h06);
    step(PO, 24, 32'h01, 5'h00);
    // Sequence check: the entry pair breaks before the handover.
    bus(1'b1, OFS_CTRL, 32'h80);
    step(PA, 24, 32'h12, 5'h18);
    step(7'h20, 24, 32'h21, 5'h06);
    step(PO, 24, 32'h01, 5'h00);
    // End through the field: muting starts on a cut field and ends when it clears.
    bus(1'b1, OFS_CTRL, 32'h40);
    step(PA, 24, 32'h12, 5'h18);
    step(PA | PF, 24, 32'h01, 5'h10);
    $display("test guards done");
    bus(1'b1, OFS_CTRL, 32'h0);
    step(PF, 24, 32'h01, 5'h10);
    slow <= 1'b1;
    step(PF | PA, 40, 32'h12, 5'h18);
    step(PF, 40, 32'h01, 5'h10);
    $display("test release done");
    complete_run();
  end
endmodule

`default_nettype wire
